//--- tb/swd_cpu_model.sv
// Purpose: Processor side: services the watchdog kick and drives RAM enable.
// Assumes: Kick requests come from the bench one cycle wide, just after an edge.
// Notes:   Kick level stays in its power-up state until the first request.
`timescale 1ns/10ps
module swd_cpu_model (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Requests from the bench
    input  wire logic kick_req,
    input  wire logic ce_req_n,
    // Pins toward the supervisor
    output logic      watchdog_kick,
    output logic      ce_in_n
);
    // =========================================================
    // Kick toggling
    // =========================================================
    // Low after reset; toggles only when software asks
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            watchdog_kick <= 1'b0;
        end else if (kick_req) begin
            watchdog_kick <= ~watchdog_kick;
        end
    end
    // Enable is a plain level, no extra delay
    assign ce_in_n = ce_req_n;
endmodule : swd_cpu_model

//--- tb/tb_supervisor_watchdog_ce_gating.sv
// Purpose: Self-checking bench for the supervisor watchdog and enable gating.
// Assumes: External timebase for long counts; OSC_DIV of 4 for internal mode.
// Notes:   Internal long timeout is not run; it would take too many cycles.
`timescale 1ns/10ps
module tb_supervisor_watchdog_ce_gating;
    localparam int DIV = 4;
    logic sys_clk = 1'b0, rst = 1'b1, lowline_sense = 1'b0, powerfail_sense_in = 1'b1;
    logic supply_below_backup = 1'b0, watchdog_kick, watchdog_kick_float = 1'b0;
    logic timebase_select = 1'b0, timebase_input = 1'b0, ce_in_n, ce_out_n, kick_req = 1'b0;
    logic timebase_select_float = 1'b0, timebase_input_float = 1'b0;
    logic ce_req_n = 1'b1, reset_n, reset_hi, powerfail_warn_n, watchdog_expired_n;
    logic [31:0] lfsr = 32'hc0a3;
    int miscompares = 0, cmp_count = 0;

    // =========================================================
    // Clock, partner and design
    // =========================================================
    always #2.5 sys_clk = ~sys_clk;
    swd_cpu_model cpu (.sys_clk(sys_clk), .rst(rst), .kick_req(kick_req), .ce_req_n(ce_req_n),
        .watchdog_kick(watchdog_kick), .ce_in_n(ce_in_n));
    swd_watchdog #(.OSC_DIV(DIV)) DUT (.sys_clk(sys_clk), .rst(rst), .lowline_sense(lowline_sense),
        .powerfail_sense_in(powerfail_sense_in), .supply_below_backup(supply_below_backup),
        .watchdog_kick(watchdog_kick), .watchdog_kick_float(watchdog_kick_float),
        .timebase_select(timebase_select), .timebase_select_float(timebase_select_float),
        .timebase_input(timebase_input), .timebase_input_float(timebase_input_float), .ce_in_n(ce_in_n),
        .ce_out_n(ce_out_n), .reset_n(reset_n), .reset_hi(reset_hi),
        .powerfail_warn_n(powerfail_warn_n), .watchdog_expired_n(watchdog_expired_n));

    // =========================================================
    // Helpers
    // =========================================================
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction : lfsr_next

    // Inputs always move 1 ns after the edge, away from sampling
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic chk(input string name, input logic seen, input logic exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %b seen %b", name, exp, seen);
        end
    endtask : chk

    // One external timebase clock, high and low one cycle each
    task automatic tick(input int n);
        repeat (n) begin
            timebase_input = 1'b1;
            cyc(1);
            timebase_input = 1'b0;
            cyc(1);
        end
    endtask : tick

    task automatic kick();
        kick_req = 1'b1;
        cyc(1);
        kick_req = 1'b0;
        cyc(3);
    endtask : kick

    // Reset must not move before tick n, and must move right after it
    task automatic span(input int n, input logic pre);
        tick(n - 1);
        cyc(4);
        chk("reset_n before", reset_n, pre);
        tick(1);
        cyc(4);
        chk("reset_n after", reset_n, ~pre);
    endtask : span

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // Watchdog on the whole run; expected length is about 48k cycles
    initial begin
        #(70000 * 5);
        miscompares++;
        summarize();
    end

    // =========================================================
    // Main sequence
    // =========================================================
    initial begin
        cyc(8);
        chk("reset_n", reset_n, 1'b0);
        chk("reset_hi", reset_hi, 1'b1);
        chk("ce_out_n", ce_out_n, 1'b1);
        chk("expired", watchdog_expired_n, 1'b1);
        rst = 1'b0;
        // Random comparator levels against the gating equations
        repeat (40) begin
            lfsr = lfsr_next(lfsr);
            lowline_sense = lfsr[0];
            powerfail_sense_in = lfsr[1];
            supply_below_backup = lfsr[2] & lfsr[3];
            ce_req_n = lfsr[4];
            cyc(4);
            chk("ce_out_n", ce_out_n, lfsr[4] | ~lfsr[0] | (lfsr[2] & lfsr[3]));
            chk("powerfail_warn_n", powerfail_warn_n, lfsr[1] & ~(lfsr[2] & lfsr[3]));
            chk("reset_hi", reset_hi, ~reset_n);
            if (!lfsr[0]) begin
                chk("reset_n low line", reset_n, 1'b0);
                chk("expired low line", watchdog_expired_n, 1'b1);
            end
        end
        lowline_sense = 1'b1;
        supply_below_backup = 1'b0;
        cyc(6);
        span(512, 1'b0);
        // No kick: post-reset limit, then flag and pulse
        span(4096, 1'b1);
        chk("expired timeout", watchdog_expired_n, 1'b0);
        tick(100);
        kick();
        span(412, 1'b0);
        chk("expired after pulse", watchdog_expired_n, 1'b0);
        span(4096, 1'b1);
        span(512, 1'b0);
        kick();
        chk("expired kick", watchdog_expired_n, 1'b1);
        tick(1000);
        kick();
        span(1024, 1'b1);
        span(512, 1'b0);
        // Undriven kick pin: no timeout at all
        watchdog_kick_float = 1'b1;
        kick();
        tick(4200);
        chk("reset_n float", reset_n, 1'b1);
        watchdog_kick_float = 1'b0;
        // Internal timebase, select pin high, input pin low: short limit after a kick
        timebase_select = 1'b1;
        kick();
        cyc(1024 * DIV - 12);
        chk("reset_n short", reset_n, 1'b1);
        cyc(20);
        chk("reset_n short end", reset_n, 1'b0);
        chk("expired internal", watchdog_expired_n, 1'b0);
        cyc(512 * DIV - 16);
        chk("pulse internal", reset_n, 1'b0);
        cyc(20);
        chk("pulse internal end", reset_n, 1'b1);
        // Undriven timebase input: long normal limit, no reset at the short mark
        timebase_input_float = 1'b1;
        kick();
        chk("expired kick internal", watchdog_expired_n, 1'b1);
        cyc(1024 * DIV + 20);
        chk("reset_n long normal", reset_n, 1'b1);
        // Undriven select keeps the internal timebase; input driven low gives short limit
        kick();
        timebase_input_float = 1'b0;
        timebase_select = 1'b0;
        timebase_select_float = 1'b1;
        cyc(1024 * DIV + 20);
        chk("reset_n select float", reset_n, 1'b0);
        chk("expired select float", watchdog_expired_n, 1'b0);
        lowline_sense = 1'b0;
        cyc(4);
        chk("expired line drop", watchdog_expired_n, 1'b1);
        chk("reset_n line drop", reset_n, 1'b0);
        summarize();
    end
endmodule : tb_supervisor_watchdog_ce_gating

//--- verilog/swd_pkg.sv
// Purpose: Shared constants for the supervisor watchdog and RAM enable gating.
// Assumes: sys_clk at 200 MHz; internal timebase nominally 10.24 kHz.
// Notes:   Intervals are held in timebase ticks; times in ms derive the internal ones.
package swd_pkg;

    // ==========================================================
    // Clock and timebase rates
    // ==========================================================
    localparam int unsigned CLK_HZ      = 200_000_000;
    localparam int unsigned OSC_HZ      = 10_240;
    // Cycles per internal tick, rounded down (19531)
    localparam int unsigned OSC_DIV_DEF = CLK_HZ / OSC_HZ;

    // ==========================================================
    // Intervals in ms and their tick counts
    // ==========================================================
    localparam int unsigned T_LONG_MS   = 1600;
    localparam int unsigned T_SHORT_MS  = 100;
    localparam int unsigned T_PULSE_MS  = 50;
    localparam int unsigned CNT_W       = 15;
    localparam logic [14:0] TK_LONG     = 15'(T_LONG_MS * OSC_HZ / 1000);
    localparam logic [14:0] TK_SHORT    = 15'(T_SHORT_MS * OSC_HZ / 1000);
    localparam logic [14:0] TK_PULSE    = 15'(T_PULSE_MS * OSC_HZ / 1000);
    // External clock mode counts
    localparam logic [14:0] TK_EXT_NORM = 15'h0400;
    localparam logic [14:0] TK_EXT_LONG = 15'h1000;
    localparam logic [14:0] TK_EXT_PULS = 15'h0200;

    // ==========================================================
    // Supervisor states
    // ==========================================================
    typedef enum logic [2:0] {
        ST_HOLD  = 3'b001,
        ST_PULSE = 3'b010,
        ST_RUN   = 3'b100
    } swd_state_e;

endpackage : swd_pkg

//--- verilog/swd_sync.sv
// Purpose: Two-flop synchroniser for a bundle of comparator levels.
// Assumes: Synchronous active-high reset.
// Notes:   Reset value is zero: low line and power fail read as low supply, the backup bit reads as not below backup.
`timescale 1ns/10ps
module swd_sync #(
    parameter int unsigned W = 3
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // Levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    // ==========================================================
    // Stages
    // ==========================================================
    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule : swd_sync

//--- verilog/swd_watchdog.sv
// Purpose: Watchdog, reset generator, RAM enable gating, power-fail warning.
// Assumes: Comparator results arrive as async levels; other pins synchronous.
// Notes:   Undriven pins are signalled by separate float inputs.
//
// Contract
// - Enable output copies input while line good
// - Low line forces enable output high
// - Supply below backup forces enable high
// - Warning low when power-fail sense low
// - Below backup: warning forced low
// - No kick in timeout gives reset pulse
// - Long timeout after reset until first kick
// - Watchdog count restarts at end of reset
// - Static kick gives pulses every long interval
// - Floating kick input disables watchdog
// - Expired low on timeout until next kick
// - Expired forced high on low line
// - Defaults are 1.6 s and 50 ms
// - Internal timebase: 100 ms or 1.6 s
// - Kicks ignored while reset asserted
// - External clock: 1024, 4096, 512 clocks
// - Internal timebase runs at 10.24 kHz
// - Reset held until line good 50 ms
// - Active-high reset is inverse of reset
`timescale 1ns/10ps
module swd_watchdog
    import swd_pkg::*;
#(
    parameter int unsigned OSC_DIV = OSC_DIV_DEF
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Comparator results, asynchronous
    input  wire logic lowline_sense,
    input  wire logic powerfail_sense_in,
    input  wire logic supply_below_backup,
    // Watchdog kick from the processor
    input  wire logic watchdog_kick,
    input  wire logic watchdog_kick_float,
    // Timebase selection
    input  wire logic timebase_select,
    input  wire logic timebase_select_float,
    input  wire logic timebase_input,
    input  wire logic timebase_input_float,
    // RAM enable gating
    input  wire logic ce_in_n,
    output logic      ce_out_n,
    // Supervisor outputs
    output logic      reset_n,
    output logic      reset_hi,
    output logic      powerfail_warn_n,
    output logic      watchdog_expired_n
);

    // ==========================================================
    // Functions
    // ==========================================================
    // Watchdog limit in ticks for the current mode
    function automatic logic [14:0] wd_limit(input logic long_w,
                                             input logic ext,
                                             input logic short_sel);
        logic [14:0] lim;
        if (ext) begin
            lim = long_w ? TK_EXT_LONG : TK_EXT_NORM;
        end else if (long_w || !short_sel) begin
            lim = TK_LONG;
        end else begin
            lim = TK_SHORT;
        end
        return lim;
    endfunction : wd_limit

    // Reset pulse length in ticks
    function automatic logic [14:0] pulse_limit(input logic ext);
        return ext ? TK_EXT_PULS : TK_PULSE;
    endfunction : pulse_limit

    // ==========================================================
    // Declarations
    // ==========================================================
    localparam logic [14:0] DIV_LAST = 15'(OSC_DIV - 1);

    logic [2:0]       sync_out;
    logic             lowline_s;
    logic             pf_s;
    logic             below_s;
    logic             ext_mode;
    logic             short_sel;
    logic [14:0]      div_cnt;
    logic             tb_q;
    logic             tick;
    logic             kick_q;
    logic             kick_edge;
    swd_state_e       state;
    logic [14:0]      cnt;
    logic             long_mode;
    logic [14:0]      lim;
    logic             timeout_hit;
    logic             pulse_done;

    // ==========================================================
    // Comparator synchronisation
    // ==========================================================
    // Analog results may change at any time
    swd_sync #(
        .W (3)
    ) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     ({lowline_sense, powerfail_sense_in, supply_below_backup}),
        .dout    (sync_out)
    );

    assign lowline_s = sync_out[2];
    assign pf_s      = sync_out[1];
    assign below_s   = sync_out[0];

    // ==========================================================
    // Timebase
    // ==========================================================
    // Select low and driven picks the external clock
    assign ext_mode  = !timebase_select && !timebase_select_float;
    assign short_sel = !timebase_input && !timebase_input_float;

    // Internal oscillator emulated by a divider
    always_ff @(posedge sys_clk) begin
        if (rst || ext_mode) begin
            div_cnt <= '0;
        end else if (div_cnt == DIV_LAST) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 15'h0001;
        end
    end

    // External clock sampled; rising edges are ticks
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tb_q <= 1'b0;
        end else begin
            tb_q <= timebase_input;
        end
    end

    assign tick = ext_mode ? (timebase_input && !tb_q)
                           : (div_cnt == DIV_LAST);

    // ==========================================================
    // Kick edge detection
    // ==========================================================
    // Either edge counts; a floating pin gives none
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            kick_q <= 1'b0;
        end else begin
            kick_q <= watchdog_kick;
        end
    end

    assign kick_edge = (watchdog_kick != kick_q) && !watchdog_kick_float;

    // ==========================================================
    // Interval decode
    // ==========================================================
    assign lim         = wd_limit(long_mode, ext_mode, short_sel);
    // Kick wins a tie; >= so a limit lowered mid-count still fires
    assign timeout_hit = (state == ST_RUN) && !watchdog_kick_float && !kick_edge
                         && tick && (cnt >= lim - 15'h0001);
    assign pulse_done  = (state == ST_PULSE) && tick
                         && (cnt == pulse_limit(ext_mode) - 15'h0001);

    // ==========================================================
    // Supervisor state machine
    // ==========================================================
    // Low line overrides all and restarts the sequence
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state     <= ST_HOLD;
            cnt       <= '0;
            long_mode <= 1'b1;
        end else if (!lowline_s) begin
            state     <= ST_HOLD;
            cnt       <= '0;
            long_mode <= 1'b1;
        end else begin
            unique case (state)
                ST_HOLD: begin
                    state <= ST_PULSE;
                    cnt   <= '0;
                end
                ST_PULSE: begin
                    // Kicks are not looked at here
                    if (pulse_done) begin
                        state     <= ST_RUN;
                        cnt       <= '0;
                        long_mode <= 1'b1;
                    end else if (tick) begin
                        cnt <= cnt + 15'h0001;
                    end
                end
                ST_RUN: begin
                    if (kick_edge) begin
                        cnt       <= '0;
                        long_mode <= 1'b0;
                    end else if (watchdog_kick_float) begin
                        cnt <= '0;
                    end else if (timeout_hit) begin
                        // Long mode is set again, so a dead kick repeats
                        state     <= ST_PULSE;
                        cnt       <= '0;
                        long_mode <= 1'b1;
                    end else if (tick) begin
                        cnt <= cnt + 15'h0001;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Expired flag
    // ==========================================================
    // Cleared by a kick seen while reset is released, or by low line
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            watchdog_expired_n <= 1'b1;
        end else if (!lowline_s) begin
            watchdog_expired_n <= 1'b1;
        end else if (timeout_hit) begin
            watchdog_expired_n <= 1'b0;
        end else if ((state == ST_RUN) && kick_edge) begin
            watchdog_expired_n <= 1'b1;
        end
    end

    // ==========================================================
    // Reset outputs
    // ==========================================================
    assign reset_n  = state[2];
    assign reset_hi = !state[2];

    // ==========================================================
    // RAM enable gating and power-fail warning
    // ==========================================================
    // Registered, so one cycle behind the synchronised levels
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ce_out_n <= 1'b1;
        end else begin
            ce_out_n <= ce_in_n || !lowline_s || below_s;
        end
    end

    // Comparator is off in backup; warning held low
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            powerfail_warn_n <= 1'b0;
        end else begin
            powerfail_warn_n <= pf_s && !below_s;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    sequence s_timeout;
        timeout_hit && lowline_s;
    endsequence

    sequence s_pulse_end;
        pulse_done && lowline_s;
    endsequence

    AST_CE_FOLLOW: assert property (@(posedge sys_clk) disable iff (rst)
        lowline_s && !below_s |=> ce_out_n == $past(ce_in_n))
        else $error("enable output did not follow input");

    AST_CE_LOWLINE: assert property (@(posedge sys_clk) disable iff (rst)
        !lowline_s |=> ce_out_n)
        else $error("enable output not forced high on low line");

    AST_CE_BACKUP: assert property (@(posedge sys_clk) disable iff (rst)
        below_s |=> ce_out_n)
        else $error("enable output not forced high in backup");

    AST_PF_WARN: assert property (@(posedge sys_clk) disable iff (rst)
        !below_s |=> powerfail_warn_n == $past(pf_s))
        else $error("warning does not track power-fail sense");

    AST_PF_BACKUP: assert property (@(posedge sys_clk) disable iff (rst)
        below_s |=> !powerfail_warn_n)
        else $error("warning not forced low in backup");

    AST_TIMEOUT: assert property (@(posedge sys_clk) disable iff (rst)
        s_timeout |=> (state == ST_PULSE) && !watchdog_expired_n && !reset_n)
        else $error("timeout did not start a reset pulse");

    AST_PULSE_END: assert property (@(posedge sys_clk) disable iff (rst)
        s_pulse_end |=> reset_n && (cnt == 15'h0000) && long_mode)
        else $error("pulse end did not restart long watchdog");

    AST_FLOAT: assert property (@(posedge sys_clk) disable iff (rst)
        watchdog_kick_float && (state == ST_RUN) && lowline_s |=> reset_n)
        else $error("floating kick input caused a reset");

    AST_WDO_LOWLINE: assert property (@(posedge sys_clk) disable iff (rst)
        !lowline_s |=> watchdog_expired_n && !reset_n)
        else $error("low line did not release expired flag");

    AST_KICK_IGNORED: assert property (@(posedge sys_clk) disable iff (rst)
        (state == ST_PULSE) && lowline_s |=> $stable(watchdog_expired_n))
        else $error("expired flag changed during reset");

    AST_RESET_INV: assert property (@(posedge sys_clk) disable iff (rst)
        reset_hi != reset_n)
        else $error("reset outputs not complementary");

endmodule : swd_watchdog
